// ==== src/dts_controller.sv ====
`timescale 1ns/1ps
// What this block does
// R01: plain binary counting is not physical order
// R02: physical walk: row6 lsb, column0 msb
// R03: cells inverted when row7 differs from row0
// R04: array hides inversion at data pins
// R05: charged test writes complement on inverted cells
// R06: refresh all 128 rows every 2ms
// R07: ras-only, auto and self refresh supported
// R08: device row counter wraps after 128 refreshes
module dts_controller
	import dts_pkg::*;
#(
	parameter int ROW_INTERVAL = dts_pkg::ROW_INTERVAL_CYC
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// test pattern request
	input wire logic walk_step,
	input wire logic walk_clear,
	input wire logic charge_mode,
	input wire logic pattern_bit,
	// physical walk result
	output logic [dts_pkg::ADDR_W-1:0] row_addr,
	output logic [dts_pkg::ADDR_W-1:0] col_addr,
	output logic [dts_pkg::CELL_W-1:0] cell_index,
	output logic cell_inverted,
	output logic write_data,
	output logic walk_done,
	// refresh control
	input wire logic [1:0] method_sel,
	input wire logic refresh_enable,
	output logic ras_n,
	output logic ref_n,
	output logic [dts_pkg::ROW_CNT_W-1:0] refresh_row,
	output logic refresh_busy,
	output logic window_done
);
	import dts_pkg::*;

	// ----------------------------------------
	// physical cell walk
	// ----------------------------------------
	logic [CELL_W-1:0] cell_q;
	logic [ADDR_W-1:0] row_q;
	logic [ADDR_W-1:0] col_q;
	logic inv_q;
	logic wdata_q;
	logic done_q;
	logic [ADDR_W-1:0] row_d;
	logic [ADDR_W-1:0] col_d;

	// R01 not plain binary
	// R02 bit order mapping
	always_comb begin
		row_d = '0;
		col_d = '0;
		// row bits lsb first: 6,1,2,3,4,5,0,7
		row_d[6] = cell_q[0];
		row_d[1] = cell_q[1];
		row_d[2] = cell_q[2];
		row_d[3] = cell_q[3];
		row_d[4] = cell_q[4];
		row_d[5] = cell_q[5];
		row_d[0] = cell_q[6];
		row_d[7] = cell_q[7];
		// column bits lsb first: 7,6,1,2,3,4,5,0
		col_d[7] = cell_q[8];
		col_d[6] = cell_q[9];
		col_d[1] = cell_q[10];
		col_d[2] = cell_q[11];
		col_d[3] = cell_q[12];
		col_d[4] = cell_q[13];
		col_d[5] = cell_q[14];
		col_d[0] = cell_q[15];
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n || walk_clear) begin
			cell_q <= 16'h0000;
			done_q <= 1'b0;
		end else if (walk_step) begin
			cell_q <= cell_q + 16'h0001;
			done_q <= (cell_q == 16'hffff);
		end
	end

	// registered outputs follow the current cell
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			row_q <= 8'h00;
			col_q <= 8'h00;
			inv_q <= 1'b0;
			wdata_q <= 1'b0;
		end else begin
			row_q <= row_d;
			col_q <= col_d;
			// R03 polarity prediction
			inv_q <= row_d[7] ^ row_d[0];
			// R05 complement inverted cells
			// R04 reads return written value, so only charge tests flip
			wdata_q <= pattern_bit ^ (charge_mode & (row_d[7] ^ row_d[0]));
		end
	end

	assign row_addr = row_q;
	assign col_addr = col_q;
	assign cell_index = cell_q;
	assign cell_inverted = inv_q;
	assign write_data = wdata_q;
	assign walk_done = done_q;

	// ----------------------------------------
	// refresh pacing
	// ----------------------------------------
	// one-cycle enable per row slot; 128 slots fit the 2ms window
	logic [15:0] pace_q;
	logic tick;
	always_ff @(posedge clk_sys) begin
		if (!rst_n || !refresh_enable) begin
			pace_q <= 16'h0000;
		end else if (pace_q == 16'(ROW_INTERVAL - 1)) begin
			pace_q <= 16'h0000;
		end else begin
			pace_q <= pace_q + 16'h0001;
		end
	end
	assign tick = refresh_enable && (pace_q == 16'(ROW_INTERVAL - 1));

	// ----------------------------------------
	// refresh sequencer
	// ----------------------------------------
	typedef enum logic [1:0] {
		DTS_IDLE,
		DTS_STROBE,
		DTS_PRECHARGE,
		DTS_SELF
	} dts_state_t;

	dts_state_t state_q;
	logic start_t;
	logic [PHASE_W-1:0] load_t;
	logic expired;
	logic ras_q;
	logic ref_q;
	logic [ROW_CNT_W-1:0] rowcnt_q;
	logic wrap_q;

	dts_phase_timer #(
		.W(PHASE_W)
	) u_timer (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.start(start_t),
		.load(load_t),
		.expired(expired)
	);

	always_comb begin
		start_t = 1'b0;
		load_t = PHASE_W'(RAS_LOW_CYC);
		case (state_q)
			DTS_IDLE: begin
				start_t = tick && (method_sel != 2'(DTS_REF_SELF));
			end
			DTS_STROBE: begin
				start_t = expired;
				load_t = PHASE_W'(PRECHARGE_CYC);
			end
			DTS_SELF: begin
				// full precharge after ref rises: the device timer may still be running
				start_t = !refresh_enable || (method_sel != 2'(DTS_REF_SELF));
				load_t = PHASE_W'(PRECHARGE_CYC);
			end
			default: begin
				start_t = 1'b0;
			end
		endcase
	end

	// R06 row every slot
	// R07 three methods
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_q <= DTS_IDLE;
			ras_q <= 1'b1;
			ref_q <= 1'b1;
		end else begin
			case (state_q)
				DTS_IDLE: begin
					if (refresh_enable && method_sel == 2'(DTS_REF_SELF)) begin
						// self refresh: device timer paces rows while ref held low
						ref_q <= 1'b0;
						state_q <= DTS_SELF;
					end else if (tick) begin
						if (method_sel == 2'(DTS_REF_AUTO)) begin
							ref_q <= 1'b0;
						end else begin
							ras_q <= 1'b0;
						end
						state_q <= DTS_STROBE;
					end
				end
				DTS_STROBE: begin
					if (expired) begin
						ras_q <= 1'b1;
						ref_q <= 1'b1;
						state_q <= DTS_PRECHARGE;
					end
				end
				DTS_PRECHARGE: begin
					if (expired) begin
						state_q <= DTS_IDLE;
					end
				end
				DTS_SELF: begin
					// leave via precharge so ras waits after ref rises
					if (!refresh_enable || method_sel != 2'(DTS_REF_SELF)) begin
						ref_q <= 1'b1;
						state_q <= DTS_PRECHARGE;
					end
				end
				default: begin
					state_q <= DTS_IDLE;
					ras_q <= 1'b1;
					ref_q <= 1'b1;
				end
			endcase
		end
	end

	// R08 mirror of 7-bit counter
	// external row address for ras-only; tracks device count under auto refresh, but does not count rows during self refresh
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rowcnt_q <= ROW_RESET;
			wrap_q <= 1'b0;
		end else begin
			wrap_q <= 1'b0;
			if (state_q == DTS_STROBE && expired) begin
				rowcnt_q <= rowcnt_q + 7'h01;
				wrap_q <= (rowcnt_q == 7'h7f);
			end
		end
	end

	assign ras_n = ras_q;
	assign ref_n = ref_q;
	assign refresh_row = rowcnt_q;
	assign refresh_busy = (state_q != DTS_IDLE);
	assign window_done = wrap_q;
endmodule : dts_controller

// ==== src/dts_pkg.sv ====
package dts_pkg;
	// ----------------------------------------
	// address and array geometry
	// ----------------------------------------
	localparam int ADDR_W = 8;
	localparam int CELL_W = 16;
	localparam int ROWS = 128;
	localparam int ROW_CNT_W = 7;
	// ----------------------------------------
	// refresh timing
	// ----------------------------------------
	localparam int CLK_HZ = 20_000_000;
	localparam int REFRESH_WINDOW_US = 2000;
	// longest time: round down, then share over all rows
	localparam int REFRESH_WINDOW_CYC = (CLK_HZ / 1_000_000) * REFRESH_WINDOW_US;
	localparam int ROW_INTERVAL_CYC = REFRESH_WINDOW_CYC / ROWS;
	localparam int RAS_LOW_CYC = 4;
	localparam int PRECHARGE_CYC = 4;
	localparam int PHASE_W = 4;
	localparam logic [ROW_CNT_W-1:0] ROW_RESET = 7'h00;
	// ----------------------------------------
	// refresh methods
	// ----------------------------------------
	typedef enum logic [1:0] {
		DTS_REF_RAS_ONLY,
		DTS_REF_AUTO,
		DTS_REF_SELF
	} dts_method_t;
endpackage : dts_pkg

// ==== src/dts_phase_timer.sv ====
`timescale 1ns/1ps
module dts_phase_timer #(
	parameter int W = 16
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// control
	input wire logic start,
	input wire logic [W-1:0] load,
	// status
	output logic expired
);
	logic [W-1:0] cnt_q;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			cnt_q <= '0;
		end else if (start) begin
			cnt_q <= load;
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end

	// expiry looks at the count only, so an owner that restarts on expiry forms no loop
	assign expired = (cnt_q == '0);
endmodule : dts_phase_timer

// ==== test/dts_properties.sv ====
`timescale 1ns/1ps
module dts_props (
	// -- watched
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic walk_step,
	input wire logic walk_clear,
	input wire logic [7:0] row_addr,
	input wire logic [15:0] cell_index,
	input wire logic cell_inverted,
	input wire logic ras_n
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	sequence s_low; (!ras_n)[*5]; endsequence
	property p_step; walk_step && !walk_clear |=> cell_index == $past(cell_index) + 16'h1; endproperty
	property p_map; $changed(cell_index) |=> row_addr[7:6] == {$past(cell_index[7]), $past(cell_index[0])}
		&& row_addr[0] == $past(cell_index[6]); endproperty
	property p_inv; cell_inverted == ($past(cell_index[7]) ^ $past(cell_index[6])); endproperty
	property p_ras; $fell(ras_n) |-> s_low ##1 ras_n; endproperty
	a_step: assert property (p_step) else $error("walk count");
	a_map: assert property (p_map) else $error("row order");
	a_inv: assert property (p_inv) else $error("polarity");
	a_ras: assert property (p_ras) else $error("strobe width");
endmodule : dts_props

// ==== test/dts_ram_model.sv ====
`timescale 1ns/1ps
module dts_ram_model (
	// -- strobes
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ras_n,
	input wire logic ref_n,
	input wire logic [6:0] refresh_row,
	// -- cell access
	input wire logic [7:0] row_addr,
	input wire logic [7:0] col_addr,
	input wire logic write_data,
	output logic read_bit,
	// -- state
	output logic [6:0] dev_row,
	output logic [127:0] seen,
	output logic [16:0] charged
);
	logic ras_q = 1'b1;
	logic ref_q = 1'b1;
	logic [3:0] tmr = 4'h0;
	bit mem [65536];
	logic [15:0] wa;
	logic pol;
	assign wa = {col_addr, row_addr};
	// inverted storage where row bits 7 and 0 differ
	assign pol = row_addr[7] ^ row_addr[0];
	assign read_bit = mem[wa] ^ pol;
	initial charged = '0;
	// power-up count is not settable, so start off zero
	initial dev_row = 7'h2a;
	initial seen = '0;
	always @(posedge clk_sys) begin
		ras_q <= ras_n;
		ref_q <= ref_n;
		tmr <= ref_n ? 4'h0 : tmr + 4'h1;
		// every cycle out of reset writes the cell in front of it; charged counts stored ones
		if (rst_n) begin
			mem[wa] <= write_data ^ pol;
			charged <= charged + 17'(write_data ^ pol) - 17'(mem[wa]);
		end
		if (ras_q && !ras_n) seen[refresh_row] <= 1'b1;
		if ((ref_q && !ref_n) || tmr == 4'h7) dev_row <= dev_row + 7'h1;
	end
endmodule : dts_ram_model

// ==== test/tb.sv ====
`timescale 1ns/1ps
module tb;
	logic clk_sys = 0, rst_n = 0, walk_step = 0, walk_clear = 0, charge_mode = 0, pattern_bit = 0, ok;
	logic refresh_enable = 0, cell_inverted, write_data, walk_done, ras_n, ref_n, refresh_busy, window_done, chg = 0;
	logic [1:0] method_sel = 2'h0;
	logic [7:0] row_addr, col_addr;
	logic [15:0] cell_index, idx, last = 0, cnt = 0;
	logic [6:0] refresh_row, dev_row, r0, rr;
	logic [127:0] seen;
	logic read_bit;
	logic [16:0] charged, pa;
	logic [16:0] q[$], e;
	int miscompares = 0, compares = 0, n;
	always #25 clk_sys = ~clk_sys;
	dts_controller #(.ROW_INTERVAL(16)) dut (.*);
	dts_ram_model ram (.*);
	task chk(input logic c, input string m);
		compares++;
		if (!c) begin
			miscompares++;
			$display("Error %0t %s", $time, m);
		end
	endtask : chk
	task give_verdict;
		$display("miscompares %0d compares %0d", miscompares, compares);
		if (miscompares == 0 && compares > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict
	task step(input logic pb, input logic cm, input int gap);
		pattern_bit <= pb;
		charge_mode <= cm;
		if (gap > 0) @(posedge clk_sys);
		walk_step <= 1'b1;
		cnt++;
		q.push_back({cnt, pb ^ (cm & (cnt[7] ^ cnt[6]))});
		@(posedge clk_sys);
		if (gap > 0) begin
			walk_step <= 1'b0;
			repeat (gap) @(posedge clk_sys);
		end
	endtask : step
	task wait_win;
		n = 0;
		while (window_done !== 1'b1) begin
			@(negedge clk_sys);
			n++;
			if (n > 3000) begin
				chk(1'b0, "timeout");
				give_verdict;
			end
		end
	endtask : wait_win
	// -- result watcher
	always @(negedge clk_sys) begin
		if (chg && q.size() > 0) begin
			e = q.pop_front();
			idx = e[16:1];
			ok = last === idx && row_addr === {idx[7], idx[0], idx[5:1], idx[6]};
			ok = ok && col_addr === {idx[8], idx[9], idx[14:10], idx[15]} && cell_inverted === (idx[7] ^ idx[6]);
			chk(ok && write_data === e[0], "walk");
		end
		if ({col_addr, row_addr, write_data} === pa) chk(read_bit === write_data, "readback");
		pa = {col_addr, row_addr, write_data};
		chg = cell_index !== last;
		last = cell_index;
	end
	initial begin
		void'($urandom(32'h5040fb45));
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		// 200 cells reach both inverted quarters
		for (int k = 0; k < 200; k++) step(1'($urandom), 1'($urandom), 3);
		walk_clear <= 1'b1;
		cnt = 0;
		q.push_back({16'h0, pattern_bit});
		@(posedge clk_sys);
		walk_clear <= 1'b0;
		@(posedge clk_sys);
		pattern_bit <= 1'b1;
		charge_mode <= 1'b1;
		repeat (3) @(posedge clk_sys);
		// back to back through the top cell and the wrap
		for (int k = 0; k < 65536; k++) step(1'b1, 1'b1, 0);
		walk_step <= 1'b0;
		repeat (4) @(negedge clk_sys);
		chk(walk_done === 1'b1 && q.size() == 0, "wrap");
		chk(charged === 17'h10000, "charged");
		@(posedge clk_sys);
		refresh_enable <= 1'b1;
		wait_win;
		chk(&seen, "rows");
		r0 = dev_row;
		rr = refresh_row;
		@(posedge clk_sys);
		method_sel <= 2'h1;
		@(negedge clk_sys);
		wait_win;
		repeat (40) @(negedge clk_sys);
		chk(dev_row - r0 === refresh_row - rr, "mirror");
		@(posedge clk_sys);
		method_sel <= 2'h2;
		r0 = dev_row;
		repeat (40) @(negedge clk_sys);
		chk(ref_n === 1'b0 && ras_n === 1'b1 && dev_row !== r0 && refresh_busy === 1'b1, "self");
		@(posedge clk_sys);
		refresh_enable <= 1'b0;
		repeat (10) @(negedge clk_sys);
		chk(ref_n === 1'b1 && refresh_busy === 1'b0, "self exit");
		give_verdict;
	end
endmodule : tb
bind dts_controller dts_props u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .walk_step(walk_step),
	.walk_clear(walk_clear), .row_addr(row_addr), .cell_index(cell_index), .cell_inverted(cell_inverted),
	.ras_n(ras_n));
